// File: apwm_pkg.sv
`default_nettype none
package apwm_pkg;
    // Register indices; byte address is four times the index
    localparam logic [3:0] APWM_IDX_STATUS = 4'h0;
    localparam logic [3:0] APWM_IDX_EXT = 4'h8;
    localparam logic [3:0] APWM_IDX_CTRL = 4'h9;
    localparam logic [3:0] APWM_IDX_MID = 4'hA;
    localparam logic [3:0] APWM_IDX_TOP = 4'hB;
    // Field positions
    localparam int APWM_BIT_REQ_FLAG = 2;
    localparam int APWM_BIT_GIE = 1;
    localparam int APWM_BIT_OUT_EN = 0;
    // Reset values
    localparam logic [3:0] APWM_RST_NIBBLE = 4'h0;
    localparam logic APWM_RST_OUT_EN = 1'b0;
    localparam logic APWM_RST_GIE = 1'b0;
    localparam logic APWM_RST_FLAG = 1'b0;
    // Timing
    localparam longint APWM_CLK_HZ = 200_000_000;
    localparam longint APWM_BASE_RATE_HZ = 32768;
    localparam longint APWM_FAST_RATE_HZ = 65536;
    localparam int APWM_PERIOD_BASE = int'(APWM_CLK_HZ / APWM_BASE_RATE_HZ);
    localparam int APWM_PERIOD_FAST = int'(APWM_CLK_HZ / APWM_FAST_RATE_HZ);
    localparam int APWM_CNT_W = 16;
    // Resolutions
    localparam int APWM_RES_8 = 8;
    localparam int APWM_RES_10 = 10;
    localparam int APWM_RES_12 = 12;
    localparam int APWM_SAMPLE_W = 12;
endpackage : apwm_pkg
`default_nettype wire

// File: apwm_if.sv
`default_nettype none
interface apwm_if #(
    parameter int CNT_W = 16,
    parameter int MAG_W = 11
);
    logic run;
    logic [CNT_W-1:0] count;
    logic period_end;
    logic [MAG_W-1:0] mag;
    logic sign;
    logic pos_lvl;
    logic neg_lvl;
    modport timer (input run, output count, output period_end);
    modport shaper (input run, input count, input mag, input sign, output pos_lvl,
        output neg_lvl);
    modport core (output run, output mag, output sign, input count, input period_end,
        input pos_lvl, input neg_lvl);
endinterface : apwm_if
`default_nettype wire

// File: apwm_period.sv
`default_nettype none
module apwm_period #(
    parameter int PERIOD = 6103
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    apwm_if.timer tmr
);
    localparam int CW = $bits(tmr.count);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
    // End pulse stands in the last count so the load lands on the wrap edge
    localparam logic [CW-1:0] PRE = CW'(PERIOD - 2);

    initial begin
        if (PERIOD < 2 || PERIOD > (1 << CW)) begin
            $error("apwm_period: period out of range");
        end
    end

    logic [CW-1:0] count_r;
    logic end_r;

    // Counter parks at zero while stopped so each start begins a full period
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !tmr.run) begin
            count_r <= '0;
        end else if (count_r == LAST) begin
            count_r <= '0;
        end else begin
            count_r <= count_r + CW'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            end_r <= 1'b0;
        end else begin
            end_r <= tmr.run && (count_r == PRE);
        end
    end

    assign tmr.count = count_r;
    assign tmr.period_end = end_r;
endmodule : apwm_period
`default_nettype wire

// File: apwm_pulse.sv
`default_nettype none
module apwm_pulse (
    apwm_if.shaper shp
);
    localparam int CW = $bits(shp.count);
    localparam int MW = $bits(shp.mag);
    logic active;

    // Pulse high for the first mag counts of the period
    assign active = shp.run && (shp.count < CW'(shp.mag));
    assign shp.pos_lvl = active && !shp.sign;
    assign shp.neg_lvl = active && shp.sign;
endmodule : apwm_pulse
`default_nettype wire

// File: apwm_top.sv
// Our own choice: the Wishbone register port.
`default_nettype none
module apwm_top #(
    parameter int RESOLUTION = apwm_pkg::APWM_RES_8,
    parameter bit DAC_MODE = 1'b0,
    parameter bit DOUBLE_RATE = 1'b0,
    parameter int PERIOD_CYCLES = DOUBLE_RATE ? apwm_pkg::APWM_PERIOD_FAST
                                              : apwm_pkg::APWM_PERIOD_BASE
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic halt_req,
    input wire logic irq_return,
    output logic irq_take,
    output logic global_irq_enable,
    output logic speaker_pos_pin_o,
    output logic speaker_pos_pin_oe,
    output logic speaker_neg_pin_o,
    output logic speaker_neg_pin_oe,
    output logic [11:0] dac_sample,
    output logic dac_sample_valid
);
    localparam int SW = apwm_pkg::APWM_SAMPLE_W;
    localparam int MAG_W = SW - 1;
    localparam int CW = apwm_pkg::APWM_CNT_W;

    initial begin
        if (RESOLUTION != apwm_pkg::APWM_RES_8 && RESOLUTION != apwm_pkg::APWM_RES_10
            && RESOLUTION != apwm_pkg::APWM_RES_12) begin
            $error("apwm_top: resolution must be 8, 10 or 12");
        end
        if (PERIOD_CYCLES <= (1 << (RESOLUTION - 1))) begin
            $error("apwm_top: period too short for full magnitude");
        end
    end

    // Software-visible state, then the halt and output-enable delay flags
    logic [3:0] ext_nib_r;
    logic [3:0] mid_nib_r;
    logic [3:0] top_nib_r;
    logic out_en_r;
    logic gie_r;
    logic flag_r;
    logic halted_r;
    logic out_en_d_r;

    // Active conversion stage
    logic act_sign_r;
    logic [MAG_W-1:0] act_mag_r;

    logic ack_r;
    logic [31:0] rdat_r;
    logic take_r;
    logic pos_r;
    logic pos_oe_r;
    logic neg_r;
    logic neg_oe_r;
    logic [11:0] dac_r;
    logic dac_vld_r;

    logic bus_req;
    logic wr_lane;
    logic [3:0] idx;
    logic wr_ext;
    logic wr_mid;
    logic wr_top;
    logic wr_ctrl;
    logic wr_status;
    logic load_now;
    logic asm_sign;
    logic [MAG_W-1:0] asm_mag;
    logic [SW-1:0] dac_word;

    apwm_if #(.CNT_W(CW), .MAG_W(MAG_W)) link ();

    apwm_period #(.PERIOD(PERIOD_CYCLES)) u_period (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tmr(link.timer)
    );

    apwm_pulse u_pulse (
        .shp(link.shaper)
    );

    // Bus decode: one access per request, ack drops the cycle after
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr_lane = bus_req && wb_we_i && wb_sel_i[0];
    assign idx = wb_adr_i[5:2];
    assign wr_ext = wr_lane && (idx == apwm_pkg::APWM_IDX_EXT);
    assign wr_mid = wr_lane && (idx == apwm_pkg::APWM_IDX_MID);
    assign wr_top = wr_lane && (idx == apwm_pkg::APWM_IDX_TOP);
    assign wr_ctrl = wr_lane && (idx == apwm_pkg::APWM_IDX_CTRL);
    assign wr_status = wr_lane && (idx == apwm_pkg::APWM_IDX_STATUS);

    // Sample assembly from written nibbles
    always_comb begin
        asm_sign = 1'b0;
        asm_mag = '0;
        if (RESOLUTION == apwm_pkg::APWM_RES_12) begin
            asm_sign = top_nib_r[3];
            asm_mag = {top_nib_r[2:0], mid_nib_r, ext_nib_r};
        end else if (RESOLUTION == apwm_pkg::APWM_RES_10) begin
            asm_sign = top_nib_r[3];
            asm_mag = MAG_W'({top_nib_r[2:0], mid_nib_r, ext_nib_r[3:2]});
        end else begin
            asm_sign = top_nib_r[3];
            asm_mag = MAG_W'({top_nib_r[2:0], mid_nib_r});
        end
    end

    // Load at each period end and at the start of output
    assign load_now = link.period_end || (out_en_r && !out_en_d_r);

    // Sign sits just above the magnitude of the chosen resolution
    always_comb begin
        dac_word = SW'(act_mag_r);
        dac_word[RESOLUTION-1] = act_sign_r;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ext_nib_r <= apwm_pkg::APWM_RST_NIBBLE;
            mid_nib_r <= apwm_pkg::APWM_RST_NIBBLE;
            top_nib_r <= apwm_pkg::APWM_RST_NIBBLE;
        end else begin
            if (wr_ext) begin
                ext_nib_r <= wb_dat_i[3:0];
            end
            if (wr_mid) begin
                mid_nib_r <= wb_dat_i[3:0];
            end
            if (wr_top) begin
                top_nib_r <= wb_dat_i[3:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            act_sign_r <= 1'b0;
            act_mag_r <= '0;
        end else if (load_now) begin
            act_sign_r <= asm_sign;
            act_mag_r <= asm_mag;
        end
    end

    // Output enable; halt wins over a simultaneous write
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            out_en_r <= apwm_pkg::APWM_RST_OUT_EN;
        end else if (halt_req) begin
            out_en_r <= 1'b0;
        end else if (wr_ctrl) begin
            out_en_r <= wb_dat_i[apwm_pkg::APWM_BIT_OUT_EN];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            out_en_d_r <= 1'b0;
        end else begin
            out_en_d_r <= out_en_r;
        end
    end

    // Pins float after halt until software enables output again
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            halted_r <= 1'b0;
        end else if (halt_req) begin
            halted_r <= 1'b1;
        end else if (wr_ctrl && wb_dat_i[apwm_pkg::APWM_BIT_OUT_EN]) begin
            halted_r <= 1'b0;
        end
    end

    // Global interrupt enable: taking clears it, return sets it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gie_r <= apwm_pkg::APWM_RST_GIE;
        end else if (gie_r && flag_r) begin
            gie_r <= 1'b0;
        end else if (irq_return) begin
            gie_r <= 1'b1;
        end else if (wr_ctrl) begin
            gie_r <= wb_dat_i[apwm_pkg::APWM_BIT_GIE];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            take_r <= 1'b0;
        end else begin
            take_r <= gie_r && flag_r;
        end
    end

    // Request flag: a period end beats a clearing write in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flag_r <= apwm_pkg::APWM_RST_FLAG;
        end else if (link.period_end) begin
            flag_r <= 1'b1;
        end else if (wr_status) begin
            flag_r <= wb_dat_i[apwm_pkg::APWM_BIT_REQ_FLAG];
        end
    end

    assign link.run = out_en_r && out_en_d_r;
    assign link.mag = act_mag_r;
    assign link.sign = act_sign_r;

    // Speaker pins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pos_r <= 1'b0;
            neg_r <= 1'b0;
            pos_oe_r <= 1'b1;
            neg_oe_r <= 1'b1;
        end else if (halted_r || halt_req) begin
            pos_r <= 1'b0;
            neg_r <= 1'b0;
            pos_oe_r <= 1'b0;
            neg_oe_r <= 1'b0;
        end else begin
            pos_oe_r <= 1'b1;
            neg_oe_r <= 1'b1;
            // DAC mode leaves the pulse pins quiet
            pos_r <= !DAC_MODE && link.pos_lvl;
            neg_r <= !DAC_MODE && link.neg_lvl;
        end
    end

    // DAC path: sign and magnitude, left-aligned to twelve bits
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dac_r <= 12'h000;
            dac_vld_r <= 1'b0;
        end else if (!DAC_MODE || !out_en_r) begin
            dac_r <= 12'h000;
            dac_vld_r <= 1'b0;
        end else begin
            dac_r <= dac_word << (SW - RESOLUTION);
            dac_vld_r <= link.run;
        end
    end

    // Wishbone slave; unmapped or write-only reads return zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r <= bus_req;
            rdat_r <= 32'h0000_0000;
            if (bus_req && !wb_we_i) begin
                unique case (idx)
                    apwm_pkg::APWM_IDX_STATUS: begin
                        rdat_r[apwm_pkg::APWM_BIT_REQ_FLAG] <= flag_r;
                    end
                    apwm_pkg::APWM_IDX_CTRL: begin
                        rdat_r[apwm_pkg::APWM_BIT_GIE] <= gie_r;
                        rdat_r[apwm_pkg::APWM_BIT_OUT_EN] <= out_en_r;
                    end
                    default: begin
                        rdat_r <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    assign irq_take = take_r;
    assign global_irq_enable = gie_r;
    assign speaker_pos_pin_o = pos_r;
    assign speaker_pos_pin_oe = pos_oe_r;
    assign speaker_neg_pin_o = neg_r;
    assign speaker_neg_pin_oe = neg_oe_r;
    assign dac_sample = dac_r;
    assign dac_sample_valid = dac_vld_r;
endmodule : apwm_top
`default_nettype wire

// File: apwm_monitor.sv
`default_nettype none
module apwm_monitor (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic halt_req,
    input wire logic irq_take,
    input wire logic global_irq_enable,
    input wire logic speaker_pos_pin_o,
    input wire logic speaker_pos_pin_oe,
    input wire logic speaker_neg_pin_o,
    input wire logic speaker_neg_pin_oe,
    input wire logic [11:0] dac_sample,
    input wire logic dac_sample_valid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic req;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    AST_ACK_NEXT:
    assert property (req |=> wb_ack_o) else $error("ack missing");
    AST_ACK_ONCE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    AST_ACK_CAUSE:
    assert property (!req |=> !wb_ack_o) else $error("ack without request");
    AST_OFF_LOW:
    assert property (req && wb_we_i && wb_adr_i[5:2] == apwm_pkg::APWM_IDX_CTRL
        && !wb_dat_i[apwm_pkg::APWM_BIT_OUT_EN]
        |-> ##3 !speaker_pos_pin_o && !speaker_neg_pin_o) else $error("pins not low");
    AST_RST_LOW:
    assert property (@(posedge ref_clk) disable iff (1'b0) !rst_n |=> speaker_pos_pin_oe
        && speaker_neg_pin_oe && !speaker_pos_pin_o && !speaker_neg_pin_o)
        else $error("pins wrong after reset");
    AST_HALT_FLOAT:
    assert property (halt_req |=> !speaker_pos_pin_oe && !speaker_neg_pin_oe
        && !speaker_pos_pin_o && !speaker_neg_pin_o) else $error("pins not floating");
    AST_ONE_PIN:
    assert property (!(speaker_pos_pin_o && speaker_neg_pin_o)) else $error("both pins high");
    AST_TAKE_GIE:
    assert property (irq_take |-> !global_irq_enable) else $error("enable kept on take");
    AST_TAKE_PULSE:
    assert property (irq_take |=> !irq_take) else $error("take pulse too long");
    AST_NO_DAC:
    assert property (dac_sample == 12'h000 && !dac_sample_valid) else $error("dac active");
endmodule : apwm_monitor
bind apwm_top apwm_monitor i_mon (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o),
    .halt_req(halt_req),
    .irq_take(irq_take),
    .global_irq_enable(global_irq_enable),
    .speaker_pos_pin_o(speaker_pos_pin_o),
    .speaker_pos_pin_oe(speaker_pos_pin_oe),
    .speaker_neg_pin_o(speaker_neg_pin_o),
    .speaker_neg_pin_oe(speaker_neg_pin_oe),
    .dac_sample(dac_sample),
    .dac_sample_valid(dac_sample_valid)
);
`default_nettype wire

// File: apwm_speaker.sv
`default_nettype none
module apwm_speaker (
    input wire logic ref_clk,
    input wire logic pos_o,
    input wire logic pos_oe,
    input wire logic neg_o,
    input wire logic neg_oe,
    output logic rep,
    output logic rep_neg,
    output logic [15:0] rep_len
);
    logic pos_l = 1'b0;
    logic neg_l = 1'b0;
    logic [15:0] pos_n = 16'h0;
    logic [15:0] neg_n = 16'h0;
    // Floating pin shows the inverse of its last level, never a stale copy
    always @(posedge ref_clk) begin
        pos_l <= pos_oe ? pos_o : ~pos_l;
        neg_l <= neg_oe ? neg_o : ~neg_l;
        pos_n <= pos_l ? pos_n + 16'h1 : 16'h0;
        neg_n <= neg_l ? neg_n + 16'h1 : 16'h0;
        rep <= (!pos_l && pos_n != 16'h0) || (!neg_l && neg_n != 16'h0);
        rep_neg <= !(!pos_l && pos_n != 16'h0);
        rep_len <= (!pos_l && pos_n != 16'h0) ? pos_n : neg_n;
    end
endmodule : apwm_speaker
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PER = 200;
    logic ref_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, halt = 1'b0, iret = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [31:0] dat = 32'h0, wdo, seed = 32'hAAA9;
    logic ack, take, gie, po, poe, no, noe, dacv, rep, rep_neg;
    logic [11:0] dac;
    logic [15:0] rep_len;
    logic [31:0] rd_q[$];
    logic [16:0] pl_q[$];
    int err_count = 0, n_tests = 0;
    int cyc_n = 0, rep_t = 0;
    initial forever #2.5 ref_clk = ~ref_clk;
    apwm_top #(.RESOLUTION(apwm_pkg::APWM_RES_8), .PERIOD_CYCLES(PER)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack),
        .halt_req(halt), .irq_return(iret), .irq_take(take), .global_irq_enable(gie),
        .speaker_pos_pin_o(po), .speaker_pos_pin_oe(poe), .speaker_neg_pin_o(no),
        .speaker_neg_pin_oe(noe), .dac_sample(dac), .dac_sample_valid(dacv));
    apwm_speaker i_spk (.ref_clk(ref_clk), .pos_o(po), .pos_oe(poe), .neg_o(no),
        .neg_oe(noe), .rep(rep), .rep_neg(rep_neg), .rep_len(rep_len));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic fail;
        err_count++;
        summarize;
    endtask : fail
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp
    // Request held until ack is sampled, then one idle cycle
    task automatic bus(input logic w, input logic [5:0] a, input logic [3:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {28'h0, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = wdo;
        cyc <= 1'b0;
        if (ack !== 1'b1) fail;
        @(posedge ref_clk);
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [3:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [3:0] e);
        logic [31:0] q;
        rd_q.push_back({28'h0, e});
        bus(1'b0, a, 4'h0, q);
    endtask : rd
    // Clear the flag, then poll until the next period begins
    task automatic sync;
        logic [31:0] q;
        int n;
        n = 0;
        q = 32'h0;
        wr(6'h00, 4'h0);
        while (q[2] !== 1'b1 && n < 200) begin
            bus(1'b0, 6'h00, 4'h0, q);
            n++;
        end
        if (q[2] !== 1'b1) fail;
    endtask : sync
    task automatic play(input logic [7:0] s);
        sync;
        wr(6'h28, s[3:0]);
        wr(6'h2C, s[7:4]);
        sync;
        pl_q.push_back({s[7], 9'h0, s[6:0]});
        pl_q.push_back({s[7], 9'h0, s[6:0]});
        sync;
        repeat (140) @(posedge ref_clk);
        cmp(32'h0, pl_q.size());
    endtask : play
    // Second pulse of a repeated sample lands one full period after the first
    always @(posedge ref_clk) begin
        cyc_n++;
        if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0) cmp(rd_q.pop_front(), wdo);
        if (rep === 1'b1 && pl_q.size() == 1) cmp(PER, cyc_n - rep_t);
        if (rep === 1'b1) rep_t = cyc_n;
        if (rep === 1'b1 && pl_q.size() > 0) cmp(pl_q.pop_front(), {rep_neg, rep_len});
    end
    initial begin
        int n;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(6'h00, 4'h0);
        rd(6'h24, 4'h0);
        rd(6'h20, 4'h0);
        rd(6'h30, 4'h0);
        cmp(32'hA, {28'h0, poe, po, noe, no});
        $display("reset test done");
        wr(6'h28, 4'h0);
        wr(6'h2C, 4'h1);
        wr(6'h24, 4'h1);
        play(8'hFF);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            play({seed[0], 7'h10 + 7'(seed[14:8] % 7'h70)});
        end
        rd(6'h00, 4'h4);
        $display("pulse test done");
        wr(6'h00, 4'h0);
        wr(6'h24, 4'h3);
        n = 0;
        while (take !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        if (take !== 1'b1) fail;
        cmp(32'h0, {31'h0, gie});
        rd(6'h00, 4'h4);
        wr(6'h00, 4'h0);
        iret <= 1'b1;
        @(posedge ref_clk);
        iret <= 1'b0;
        rd(6'h24, 4'h3);
        wr(6'h24, 4'h1);
        $display("interrupt test done");
        halt <= 1'b1;
        @(posedge ref_clk);
        halt <= 1'b0;
        repeat (2) @(posedge ref_clk);
        cmp(32'h0, {28'h0, poe, po, noe, no});
        rd(6'h24, 4'h0);
        wr(6'h24, 4'h1);
        wr(6'h24, 4'h0);
        repeat (3) @(posedge ref_clk);
        cmp(32'hA, {28'h0, poe, po, noe, no});
        $display("halt and disable test done");
        summarize;
    end
endmodule : testbench
`default_nettype wire
